/* File: rtl/direct_pin_control_config.sv */
// forced register configuration under direct pin control
// How it works
// R1 - bus_disable_n low: pins become reset, divider, gain
// R2 - reset pin low clears all registers, low power
// R3 - reset pin high leaves low power, becomes active
// R4 - divider_select low sets lo_divide_sel bit
// R5 - divider_select high clears lo_divide_sel bit
// R6 - gain high: gain field all zero
// R7 - gain low: gain field pattern 01001
// R8 - pin mode with reset pin high forces bias and demod enables
// R9 - drive, phase, offset, intermod held zero
// R10 - mode register: channel zero, trim ones
// R11 - all pins synchronised before use
`timescale 1ns/100ps
`include "pin_cfg_params.svh"
module direct_pin_control_config
  import pin_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // device pins
  input  wire logic       bus_disable_n_i,
  input  wire logic       serial_cmd_in_i,
  input  wire logic       serial_clk_i,
  input  wire logic       serial_select_n_i,
  // forced register contents
  output logic [7:0]      general_control_o,
  output logic [7:0]      gain_drive_control_o,
  output logic [7:0]      channel_mode_o,
  output logic [7:0]      dc_offset_trim_o,
  output logic [7:0]      intermod_trim_o,
  // status
  output logic            pin_mode_o,
  output logic            low_power_o,
  output logic            forcing_o
);

  // ****************************************
  // pin synchronisation
  // ****************************************
  logic [3:0] pins_raw;
  logic [3:0] pins_sync;

  // stored inverted so the cleared flops read as idle-high pins, no false pin mode after reset
  assign pins_raw = ~{bus_disable_n_i, serial_cmd_in_i, serial_clk_i, serial_select_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      pin_sync u_sync (                                          // R11
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .pin_i   (pins_raw[gi]),
        .level_o (pins_sync[gi])
      );
    end
  endgenerate

  // ****************************************
  // pin roles in direct mode
  // ****************************************
  wire bus_disable_n  = ~pins_sync[3];
  wire pin_reset_n    = ~pins_sync[2];                           // R1
  wire divider_select = ~pins_sync[1];                           // R1
  wire gain_select    = ~pins_sync[0];                           // R1
  wire pin_mode       = ~bus_disable_n;                          // R1

  // ****************************************
  // mode state machine
  // ****************************************
  cfg_state_t state_r;
  cfg_state_t state_nxt;

  always_comb begin
    case (state_r)
      ST_BUS: begin
        if (pin_mode) state_nxt = pin_reset_n ? ST_ACTIVE : ST_LOWPWR;
        else state_nxt = ST_BUS;
      end
      ST_LOWPWR: begin
        if (!pin_mode) state_nxt = ST_BUS;
        else if (pin_reset_n) state_nxt = ST_ACTIVE;             // R3
        else state_nxt = ST_LOWPWR;                              // R2
      end
      ST_ACTIVE: begin
        if (!pin_mode) state_nxt = ST_BUS;
        else if (!pin_reset_n) state_nxt = ST_LOWPWR;            // R2
        else state_nxt = ST_ACTIVE;
      end
      default: state_nxt = ST_LOWPWR;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) state_r <= ST_LOWPWR;
    else state_r <= state_nxt;
  end

  // ****************************************
  // forced values
  // ****************************************
  wire active_nxt = (state_nxt == ST_ACTIVE);
  wire lowpwr_nxt = (state_nxt == ST_LOWPWR);
  wire pin_nxt    = active_nxt | lowpwr_nxt;

  // divider low selects divide by two
  wire [7:0] gc_div   = divider_select ? `REG_CLEAR : `GC_DIV2;   // R4 R5
  wire [7:0] gc_nxt   = active_nxt ? (`GC_ENABLES | gc_div) :
                        lowpwr_nxt ? `REG_CLEAR : general_control_o;  // R8 R2
  wire [7:0] gain_val = gain_select ? `GAIN_MAX : `GAIN_MINUS18;  // R6 R7
  wire [7:0] ctl_nxt  = active_nxt ? gain_val :                   // R9
                        lowpwr_nxt ? `REG_CLEAR : gain_drive_control_o;
  wire [7:0] mode_nxt = active_nxt ? `MODE_FORCED :               // R10
                        lowpwr_nxt ? `REG_CLEAR : channel_mode_o;
  wire [7:0] ofs_nxt  = pin_nxt ? `REG_CLEAR : dc_offset_trim_o;  // R9
  wire [7:0] imd_nxt  = pin_nxt ? `REG_CLEAR : intermod_trim_o;   // R9

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      general_control_o    <= `REG_CLEAR;
      gain_drive_control_o <= `REG_CLEAR;
      channel_mode_o       <= `REG_CLEAR;
      dc_offset_trim_o     <= `REG_CLEAR;
      intermod_trim_o      <= `REG_CLEAR;
      pin_mode_o           <= 1'b0;
      low_power_o          <= 1'b1;
      forcing_o            <= 1'b0;
    end else begin
      general_control_o    <= gc_nxt;
      gain_drive_control_o <= ctl_nxt;
      channel_mode_o       <= mode_nxt;
      dc_offset_trim_o     <= ofs_nxt;
      intermod_trim_o      <= imd_nxt;
      pin_mode_o           <= pin_nxt;
      low_power_o          <= lowpwr_nxt;                        // R2 R3
      forcing_o            <= active_nxt;
    end
  end
endmodule : direct_pin_control_config

/* File: rtl/pin_cfg_params.svh */
// constants for the pin-driven configuration block
`ifndef PIN_CFG_PARAMS_SVH
`define PIN_CFG_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_GENERAL_CONTROL   8'h1B
`define OFS_GAIN_DRIVE_CTRL   8'h1C
`define OFS_CHANNEL_MODE      8'h1D
`define OFS_DC_OFFSET_TRIM    8'h1F
`define OFS_INTERMOD_TRIM     8'h2F

// ****************************************
// field positions and values
// ****************************************
`define GC_LO_DIVIDE_BIT      7
`define GC_BIAS_ENABLE_BIT    4
`define GC_DEMOD_ENABLE_BIT   1
`define REG_CLEAR             8'h00
`define GC_ENABLES            8'h12
`define GC_DIV2               8'h80
`define GAIN_MAX              8'h00
`define GAIN_MINUS18          8'h09
`define MODE_FORCED           8'h0F
`define SYNC_ZERO             4'h0

`endif

/* File: rtl/pin_cfg_pkg.sv */
// types for the pin-driven configuration block
package pin_cfg_pkg;
  typedef enum logic [2:0] {
    ST_BUS    = 3'h1,
    ST_LOWPWR = 3'h2,
    ST_ACTIVE = 3'h4
  } cfg_state_t;
endpackage : pin_cfg_pkg

/* File: rtl/pin_sync.sv */
// two-flop synchroniser for one pin
`timescale 1ns/100ps
module pin_sync (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // pin and synchronised level
  input  wire logic pin_i,
  output logic      level_o
);
  logic meta_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r  <= 1'b0;
      level_o <= 1'b0;
    end else begin
      meta_r  <= pin_i;
      level_o <= meta_r;
    end
  end
endmodule : pin_sync

/* File: dv/pin_cfg_props.sv */
// assertion checker for the pin-driven configuration block
`timescale 1ns/100ps
module pin_cfg_props (
  input wire logic mclk_i, rst_i, bus_disable_n_i, serial_cmd_in_i, serial_clk_i, serial_select_n_i,
  input wire logic [7:0] general_control_o, gain_drive_control_o, channel_mode_o, dc_offset_trim_o, intermod_trim_o,
  input wire logic pin_mode_o, low_power_o, forcing_o
);
  // history valid once three edges have passed since reset
  logic [1:0] up_r;
  wire        ok = up_r == 2'h3;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i) up_r <= 2'h0;
    else if (!ok) up_r <= up_r + 2'h1;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence act_s; ok && !$past(bus_disable_n_i, 3) && $past(serial_cmd_in_i, 3); endsequence
  sequence low_s; ok && !$past(bus_disable_n_i, 3) && !$past(serial_cmd_in_i, 3); endsequence
  mode_flag_a: assert property (ok |-> pin_mode_o == !$past(bus_disable_n_i, 3)) else $error("mode flag");
  reset_clear_a:
    assert property (low_s |-> low_power_o && !forcing_o && {general_control_o, gain_drive_control_o,
      channel_mode_o, dc_offset_trim_o, intermod_trim_o} == 40'h0) else $error("reset state");
  wake_up_a: assert property (act_s |-> forcing_o && !low_power_o) else $error("active state");
  divide_bit_a:
    assert property (act_s |-> general_control_o[7] == !$past(serial_clk_i, 3)) else $error("divide bit");
  enables_a: assert property (act_s |-> general_control_o[6:0] == 7'h12) else $error("enable bits");
  gain_field_a:
    assert property (act_s |-> gain_drive_control_o == ($past(serial_select_n_i, 3) ? 8'h00 : 8'h09))
      else $error("gain field");
  trims_zero_a: assert property (act_s |-> {dc_offset_trim_o, intermod_trim_o} == 16'h0) else $error("trims");
  mode_reg_a: assert property (act_s |-> channel_mode_o == 8'h0F) else $error("mode register");
  cover property (act_s);
  cover property (low_s);
  cover property (ok && !pin_mode_o);
endmodule : pin_cfg_props
bind direct_pin_control_config pin_cfg_props u_props (.*);

/* File: dv/pin_strap.sv */
// board strapping model driving the direct control pins
`timescale 1ns/100ps
module pin_strap (
  input  wire logic       mclk_i,
  input  wire logic [3:0] lvl_i,
  output logic            bus_disable_n_i, serial_cmd_in_i, serial_clk_i, serial_select_n_i
);
  // order: bus disable, pin reset, divider select, gain select
  logic [3:0] pins_r = 4'hF;
  always_ff @(posedge mclk_i) pins_r <= lvl_i;
  assign {bus_disable_n_i, serial_cmd_in_i, serial_clk_i, serial_select_n_i} = pins_r;
endmodule : pin_strap

/* File: dv/tb_direct_pin_control_config.sv */
// testbench for the pin-driven configuration block
`timescale 1ns/100ps
module tb_direct_pin_control_config;
  logic       mclk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [3:0] lvl_i = 4'hF;
  logic       bus_disable_n_i, serial_cmd_in_i, serial_clk_i, serial_select_n_i;
  logic [7:0] general_control_o, gain_drive_control_o, channel_mode_o, dc_offset_trim_o, intermod_trim_o;
  logic       pin_mode_o, low_power_o, forcing_o;
  int         err_total = 0;
  int         tests_run = 0;
  initial forever #25 mclk_i = ~mclk_i;
  pin_strap strap (.*);
  direct_pin_control_config uut (.*);
  task chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task put(input logic [3:0] l);
    @(posedge mclk_i);
    lvl_i <= l;
    repeat (5) @(posedge mclk_i);
    #1;
  endtask : put
  task t_active;
    for (int i = 0; i < 4; i++) begin
      put({2'h1, i[1:0]});
      chk("gen_ctrl", general_control_o, {!i[1], 7'h12});
      chk("gain", gain_drive_control_o, i[0] ? 8'h00 : 8'h09);
      chk("mode", channel_mode_o, 8'h0F);
      chk("trims", {dc_offset_trim_o, intermod_trim_o}, 16'h0);
      chk("flags", {pin_mode_o, forcing_o, low_power_o}, 3'h6);
    end
  endtask : t_active
  task t_reset;
    put(4'h3);
    chk("regs", {general_control_o, gain_drive_control_o, channel_mode_o, dc_offset_trim_o, intermod_trim_o}, 40'h0);
    chk("flags", {pin_mode_o, forcing_o, low_power_o}, 3'h5);
    put(4'h4);
    chk("gen_ctrl", general_control_o, 8'h92);
    chk("gain", gain_drive_control_o, 8'h09);
    chk("flags", {pin_mode_o, forcing_o, low_power_o}, 3'h6);
  endtask : t_reset
  task t_bus;
    put(4'hF);
    chk("flags", {pin_mode_o, forcing_o, low_power_o}, 3'h0);
    chk("gen_ctrl", general_control_o, 8'h92);
  endtask : t_bus
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_active();
    t_reset();
    t_bus();
    end_sim();
  end
  initial begin
    repeat (400) @(posedge mclk_i);
    err_total++;
    end_sim();
  end
endmodule : tb_direct_pin_control_config
